// [bench/tcc_debugger.sv]
// Debugger model driving the register port
`timescale 1ns/1ps
module tcc_debugger
(
    input wire logic clk,
    input wire tcc_pkg::tcc_word_t rdata,
    input wire logic ready,
    output logic sel,
    output logic write,
    output tcc_pkg::tcc_addr_t addr,
    output tcc_pkg::tcc_word_t wdata
);
    import tcc_pkg::*;
    initial
    begin
        sel = 1'b0;
        write = 1'b0;
        addr = 16'h0000;
        wdata = 32'h0000_0000;
    end
    // One-cycle select: a held select would be taken twice
    task automatic access(input logic wr, input tcc_addr_t a,
        input tcc_word_t d, output tcc_word_t q, output logic ok);
        int n;
        @(posedge clk);
        #1;
        sel = 1'b1;
        write = wr;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        sel = 1'b0;
        n = 0;
        while (ready !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        q = rdata;
        ok = (ready === 1'b1);
        write = ~wr;
        addr = ~a;
        wdata = ~d;
    endtask
endmodule

// [bench/tcc_slice_sva.sv]
// Port assertions for the trace counter and claim slice
`timescale 1ns/1ps
module tcc_slice_chk
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic REG_SEL,
    input wire logic REG_WRITE,
    input wire tcc_pkg::tcc_addr_t REG_ADDR,
    input wire tcc_pkg::tcc_word_t REG_WDATA,
    input wire tcc_pkg::tcc_word_t REG_RDATA,
    input wire logic REG_READY,
    input wire logic CTX_MATCH
);
    import tcc_pkg::*;
    logic rd;
    assign rd = REG_SEL && !REG_WRITE;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    a_ready_after_sel: assert property (REG_SEL |=> REG_READY)
        else $error("ready missing after access");
    a_ready_no_sel: assert property (!REG_SEL |=> !REG_READY)
        else $error("ready without access");
    a_rdata_held: assert property (REG_SEL && REG_WRITE |=> $stable(REG_RDATA))
        else $error("read data moved on a write");
    a_preamble_upper: assert property (rd && (REG_ADDR inside
        {16'h0FF0, 16'hFFF4, 16'h0FF8, 16'h0FFC}) |=> REG_RDATA[31:8] == 24'h0)
        else $error("preamble upper bits set");
    a_claim_impl: assert property (rd && REG_ADDR == 16'h0FA0
        |=> REG_RDATA == 32'h0000_000F) else $error("claim set read wrong");
    a_cmp_hi_zero: assert property (rd && REG_ADDR == 16'h0604
        |=> REG_RDATA == 32'h0) else $error("compare upper half not zero");
    a_claim_upper: assert property (rd && REG_ADDR == 16'h0FA4
        |=> REG_RDATA[31:4] == 28'h0) else $error("claim tag upper bits set");
    a_count_upper: assert property (rd && (REG_ADDR inside
        {16'h0160, 16'h0164}) |=> REG_RDATA[31:16] == 16'h0)
        else $error("count upper bits set");
    a_ctrl_reserved: assert property (rd && REG_ADDR == 16'h0154
        |=> REG_RDATA[31:18] == 14'h0 && REG_RDATA[14:12] == 3'h0
        && REG_RDATA[6:4] == 3'h0) else $error("control reserved bits set");
    a_full_mask: assert property (REG_SEL && REG_WRITE
        && REG_ADDR == 16'h0680 && REG_WDATA[3:0] == 4'hF |=> ##1 CTX_MATCH)
        else $error("full mask gave no match");
endmodule

bind tcc_slice tcc_slice_chk u_chk (.CLOCK(CLOCK), .RST(RST),
    .REG_SEL(REG_SEL), .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_READY(REG_READY),
    .CTX_MATCH(CTX_MATCH));

// [bench/tcc_slice_tb.sv]
// Self-checking bench for the trace counter and claim slice
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_slice_tb;
    import tcc_pkg::*;
    logic clk, rst, sel, write, ready, match;
    logic ev0, ev1;
    tcc_addr_t addr;
    tcc_word_t wdata, rdata, cid;
    tcc_single_t res;
    tcc_pair_t pair;
    int fails, cmp_count;
    tcc_slice u_dut (.CLOCK(clk), .RST(rst), .REG_SEL(sel),
        .REG_WRITE(write), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_READY(ready), .RESOURCE(res),
        .RESOURCE_PAIR(pair), .CONTEXT_ID(cid), .CTX_MATCH(match),
        .RELOAD0_EVENT(ev0), .RELOAD1_EVENT(ev1));
    tcc_debugger u_dbg (.clk(clk), .rdata(rdata), .ready(ready), .sel(sel),
        .write(write), .addr(addr), .wdata(wdata));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input tcc_word_t exp,
        input tcc_word_t got);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input tcc_addr_t a, input tcc_word_t d,
        output tcc_word_t q);
        logic ok;
        u_dbg.access(w, a, d, q, ok);
        if (ok !== 1'b1)
        begin
            fails++;
            $display("BAD ready expected 1 seen 0");
            final_report();
        end
    endtask
    task automatic wr(input tcc_addr_t a, input tcc_word_t d);
        tcc_word_t q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input tcc_addr_t a, input tcc_word_t exp, string n);
        tcc_word_t q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(n, exp, q);
    endtask
    task automatic hold(input tcc_single_t s, input tcc_pair_t p, int n);
        @(posedge clk);
        #1;
        res = s;
        pair = p;
        repeat (n) @(posedge clk);
        #1;
        res = 16'h0000;
        pair = 8'h00;
    endtask
    function automatic logic exp_match(input logic [3:0] m,
        input tcc_word_t v, input tcc_word_t id);
        exp_match = 1'b1;
        for (int i = 0; i < 4; i++)
            if (!m[i] && v[8*i+:8] != id[8*i+:8])
                exp_match = 1'b0;
    endfunction
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        tcc_word_t v, c, id;
        int s, r, p, q, n, rv;
        logic e;
        fails = 0;
        cmp_count = 0;
        rst = 1'b1;
        res = 16'h0000;
        pair = 8'h00;
        cid = 32'h0000_0000;
        void'($urandom(20102));
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        rd(16'h0150, 32'h0, "ctrl0_reset");
        wr(16'h0010, $urandom);
        rd(16'h0010, 32'h0, "unmapped");
        wr(16'h0FF8, 32'hFFFF_FFFF);
        rd(16'h0FF0, {24'h0, `TCC_PRE0_DEF}, "pre0");
        rd(16'hFFF4, {24'h0, `TCC_PRE1_DEF}, "pre1");
        rd(16'h0FF8, {24'h0, `TCC_PRE2_DEF}, "pre2");
        rd(16'h0FFC, {24'h0, `TCC_PRE3_DEF}, "pre3");
        repeat (4)
        begin
            v = $urandom;
            c = $urandom;
            wr(16'h0FA4, 32'h0000_000F);
            wr(16'h0FA0, v);
            rd(16'h0FA4, v & 32'hF, "claim_set");
            wr(16'h0FA4, c);
            rd(16'h0FA4, v & ~c & 32'hF, "claim_clr");
            rd(16'h0FA0, 32'hF, "claim_impl");
        end
        for (int k = 0; k < 16; k++)
        begin
            v = $urandom;
            id = v ^ (($urandom & 32'h0101_0101) * 32'hFF);
            wr(16'h0600, v);
            wr(16'h0604, $urandom);
            rd(16'h0600, v, "cmp_lo");
            rd(16'h0604, 32'h0, "cmp_hi");
            wr(16'h0680, k | ($urandom & 32'hFFFF_FFF0));
            rd(16'h0680, k, "mask");
            cid = id;
            repeat (2) @(posedge clk);
            #1;
            e = exp_match(k, v, id);
            check("match", {31'h0, e}, {31'h0, match});
        end
        repeat (4)
        begin
            s = $urandom % 16;
            r = (s + 1 + $urandom % 15) % 16;
            p = $urandom % 8;
            q = (p + 1 + $urandom % 7) % 8;
            rv = $urandom % 65535 + 1;
            n = 3 + $urandom % 5;
            c = (r << 8) | s | ($urandom & 32'hFFFE_7070);
            wr(16'h0140, rv);
            wr(16'h0150, c);
            rd(16'h0150, c & 32'h0001_8F8F, "ctrl0");
            wr(16'h0160, n);
            hold(16'h1 << s, 8'h00, n + 2);
            check("no_reload0", 32'h0, {31'h0, ev0});
            rd(16'h0160, 32'h0, "floor");
            hold(16'h1 << r, 8'h00, 1);
            check("reload0_evt", 32'h1, {31'h0, ev0});
            rd(16'h0160, rv, "reload");
            wr(16'h0150, c | 32'h0001_0000);
            wr(16'h0160, 1);
            hold(16'h1 << s, 8'h00, 2);
            rd(16'h0160, rv, "self_reload");
            wr(16'h0150, 32'h8080 | (q << 8) | p);
            wr(16'h0160, 5);
            hold(16'hFFFF, 8'h00, 1);
            rd(16'h0160, 5, "pair_kind");
            hold(16'h0000, 8'h1 << p, 2);
            rd(16'h0160, 3, "pair_count");
            hold(16'h0000, 8'h1 << q, 1);
            rd(16'h0160, rv, "pair_reload");
            wr(16'h0150, r << 8);
            wr(16'h0154, 32'hFFFE_F0F0 | 32'h0002_8080);
            rd(16'h0154, 32'h0002_8080, "ctrl1");
            wr(16'h0164, 10);
            hold(16'h1 << r, 8'h00, 1);
            rd(16'h0164, 9, "linked");
            wr(16'h0154, 32'h0000_8080);
            hold(16'h1 << r, 8'h00, 1);
            rd(16'h0164, 9, "unlinked");
            // Counter1 reload through pair 0, counter0 left on singles
            wr(16'h0144, rv);
            hold(16'h0000, 8'h01, 1);
            check("reload1_evt", 32'h1, {31'h0, ev1});
            rd(16'h0164, rv, "reload1");
        end
        // Mid-run reset must clear the claim tag and counter1
        wr(16'h0FA0, 32'h0000_0005);
        @(posedge clk);
        #1;
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        rd(16'h0FA4, 32'h0, "claim_reset");
        rd(16'h0164, 32'h0, "count_reset");
        rd(16'h0154, 32'h0, "ctrl1_reset");
        final_report();
    end
endmodule

// [rtl/tcc_defines.svh]
// Offsets, field positions, writable masks and reset values of the trace slice
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define TCC_OFS_RELOAD0 16'h0140
`define TCC_OFS_RELOAD1 16'h0144
`define TCC_OFS_CTRL0 16'h0150
`define TCC_OFS_CTRL1 16'h0154
`define TCC_OFS_VALUE0 16'h0160
`define TCC_OFS_VALUE1 16'h0164
`define TCC_OFS_CMP_LO 16'h0600
`define TCC_OFS_CMP_HI 16'h0604
`define TCC_OFS_MASK 16'h0680
`define TCC_OFS_CLAIM_SET 16'h0FA0
`define TCC_OFS_CLAIM_CLR 16'h0FA4
`define TCC_OFS_PRE0 16'h0FF0
`define TCC_OFS_PRE1 16'hFFF4
`define TCC_OFS_PRE2 16'h0FF8
`define TCC_OFS_PRE3 16'h0FFC

// ************************************************************
// Field positions and writable masks
// ************************************************************
`define TCC_BIT_LINK 17
`define TCC_BIT_RELOAD_AT_ZERO 16
`define TCC_BIT_RELOAD_KIND 15
`define TCC_RELOAD_SEL_HI 11
`define TCC_RELOAD_SEL_LO 8
`define TCC_BIT_COUNT_KIND 7
`define TCC_COUNT_SEL_HI 3
`define TCC_COUNT_SEL_LO 0
`define TCC_CTRL0_MASK 32'h0001_8F8F
`define TCC_CTRL1_MASK 32'h0003_8F8F
`define TCC_MASK_MASK 32'h0000_000F
`define TCC_CLAIM_IMPL 4'hF

// ************************************************************
// Reset values and preamble bytes (arbitrary values)
// ************************************************************
`define TCC_RST_CTRL 32'h0000_0000
`define TCC_RST_COUNT 16'h0000
`define TCC_RST_WORD 32'h0000_0000
`define TCC_RST_CLAIM 4'h0
`define TCC_PRE0_DEF 8'h11
`define TCC_PRE1_DEF 8'h22
`define TCC_PRE2_DEF 8'h33
`define TCC_PRE3_DEF 8'h44

`endif

// [rtl/tcc_pkg.sv]
// Types shared by the trace counter and claim slice
package tcc_pkg;
    typedef logic [15:0] tcc_addr_t;
    typedef logic [31:0] tcc_word_t;
    typedef logic [15:0] tcc_count_t;
    typedef logic [15:0] tcc_single_t;
    typedef logic [7:0] tcc_pair_t;
endpackage

// [rtl/tcc_slice.sv]
// Trace counters, context compare, claim tag and preamble registers
// Operation
// RULE_01 - Mask bit one drops that value byte
// RULE_02 - Mask bit zero keeps byte compared
// RULE_03 - Compare value low half, upper reads zero
// RULE_04 - Four read-only preamble bytes, upper zero
// RULE_05 - Claim clear read shows current claim tag
// RULE_06 - Claim clear write clears bits written one
// RULE_07 - Claim set read shows implemented bits
// RULE_08 - Claim set write sets bits written one
// RULE_09 - Self reload off: reload only by resource
// RULE_10 - Self reload on: reload at zero counting
// RULE_11 - Bit 15 picks reload source kind
// RULE_12 - Reload selector picks single or pair
// RULE_13 - Bit 7 picks count source kind
// RULE_14 - Count selector picks single or pair
// RULE_15 - Linked second counter decrements on first reload
// RULE_16 - Unlinked second counter counts on own resource
// RULE_17 - Reload event copies reload value in
// RULE_18 - Present count readable in value register
// RULE_19 - Decrement once per active cycle, no wrap
// RULE_20 - Reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "tcc_defines.svh"

// ************************************************************
// One resource-driven counter
// ************************************************************
module tcc_counter
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] ctrl,
    input wire tcc_pkg::tcc_count_t reload_value,
    input wire tcc_pkg::tcc_single_t single_res,
    input wire tcc_pkg::tcc_pair_t pair_res,
    input wire logic chain_event,
    input wire logic write_value,
    input wire tcc_pkg::tcc_count_t write_data,
    output tcc_pkg::tcc_count_t count,
    output logic reload_event
);
    import tcc_pkg::*;

    logic [3:0] reload_sel;
    logic [3:0] count_sel;
    logic reload_res;
    logic count_res;
    logic decrement;
    tcc_count_t next_count;

    assign reload_sel = ctrl[`TCC_RELOAD_SEL_HI:`TCC_RELOAD_SEL_LO];
    assign count_sel = ctrl[`TCC_COUNT_SEL_HI:`TCC_COUNT_SEL_LO];

    always_comb
    begin
        if (ctrl[`TCC_BIT_RELOAD_KIND]) // [RULE_11]
        begin
            reload_res = pair_res[reload_sel[2:0]]; // [RULE_12]
        end
        else
        begin
            reload_res = single_res[reload_sel]; // [RULE_12]
        end
        if (ctrl[`TCC_BIT_COUNT_KIND]) // [RULE_13]
        begin
            count_res = pair_res[count_sel[2:0]]; // [RULE_14]
        end
        else
        begin
            count_res = single_res[count_sel]; // [RULE_14]
        end
    end

    // Self reload adds to, never replaces, the resource reload
    assign reload_event = reload_res
        | (ctrl[`TCC_BIT_RELOAD_AT_ZERO] & (count == `TCC_RST_COUNT)
           & count_res); // [RULE_09] [RULE_10]
    assign decrement = count_res | chain_event; // [RULE_15] [RULE_16]

    always_comb
    begin
        next_count = count;
        if (write_value)
        begin
            next_count = write_data;
        end
        else if (reload_event)
        begin
            next_count = reload_value; // [RULE_17]
        end
        else if (decrement && (count != `TCC_RST_COUNT))
        begin
            next_count = count - 16'h0001; // [RULE_19]
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count <= `TCC_RST_COUNT;
        end
        else
        begin
            count <= next_count;
        end
    end
endmodule

// ************************************************************
// Top: register port and slice logic
// ************************************************************
module tcc_slice
#(
    parameter logic [7:0] PREAMBLE_0 = `TCC_PRE0_DEF,
    parameter logic [7:0] PREAMBLE_1 = `TCC_PRE1_DEF,
    parameter logic [7:0] PREAMBLE_2 = `TCC_PRE2_DEF,
    parameter logic [7:0] PREAMBLE_3 = `TCC_PRE3_DEF
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic REG_SEL,
    input wire logic REG_WRITE,
    input wire tcc_pkg::tcc_addr_t REG_ADDR,
    input wire tcc_pkg::tcc_word_t REG_WDATA,
    output tcc_pkg::tcc_word_t REG_RDATA,
    output logic REG_READY,
    input wire tcc_pkg::tcc_single_t RESOURCE,
    input wire tcc_pkg::tcc_pair_t RESOURCE_PAIR,
    input wire tcc_pkg::tcc_word_t CONTEXT_ID,
    output logic CTX_MATCH,
    output logic RELOAD0_EVENT,
    output logic RELOAD1_EVENT
);
    import tcc_pkg::*;

    logic wr;
    logic rd;
    logic [31:0] counter0_control;
    logic [31:0] counter1_control;
    tcc_count_t reload0;
    tcc_count_t reload1;
    tcc_word_t context_id_compare_value;
    logic [3:0] ctx_byte_mask;
    logic [3:0] claim_tag;
    tcc_count_t count0;
    tcc_count_t count1;
    logic reload0_event;
    logic reload1_event;
    logic chain1;
    logic [3:0] byte_equal;
    tcc_word_t next_rdata;

    assign wr = REG_SEL & REG_WRITE;
    assign rd = REG_SEL & ~REG_WRITE;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            counter0_control <= `TCC_RST_CTRL;
            counter1_control <= `TCC_RST_CTRL;
            reload0 <= `TCC_RST_COUNT;
            reload1 <= `TCC_RST_COUNT;
            context_id_compare_value <= `TCC_RST_WORD;
            ctx_byte_mask <= 4'h0;
        end
        else if (wr)
        begin
            if (REG_ADDR == `TCC_OFS_CTRL0)
            begin
                counter0_control <= REG_WDATA & `TCC_CTRL0_MASK; // [RULE_20]
            end
            else if (REG_ADDR == `TCC_OFS_CTRL1)
            begin
                counter1_control <= REG_WDATA & `TCC_CTRL1_MASK; // [RULE_20]
            end
            else if (REG_ADDR == `TCC_OFS_RELOAD0)
            begin
                reload0 <= REG_WDATA[15:0];
            end
            else if (REG_ADDR == `TCC_OFS_RELOAD1)
            begin
                reload1 <= REG_WDATA[15:0];
            end
            else if (REG_ADDR == `TCC_OFS_CMP_LO)
            begin
                context_id_compare_value <= REG_WDATA; // [RULE_03]
            end
            else if (REG_ADDR == `TCC_OFS_MASK)
            begin
                ctx_byte_mask <= REG_WDATA[3:0]; // [RULE_20]
            end
        end
    end

    // ************************************************************
    // Claim tag
    // ************************************************************
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            claim_tag <= `TCC_RST_CLAIM;
        end
        else if (wr && (REG_ADDR == `TCC_OFS_CLAIM_SET))
        begin
            claim_tag <= claim_tag | REG_WDATA[3:0]; // [RULE_08]
        end
        else if (wr && (REG_ADDR == `TCC_OFS_CLAIM_CLR))
        begin
            claim_tag <= claim_tag & ~REG_WDATA[3:0]; // [RULE_06]
        end
    end

    // ************************************************************
    // Counters
    // ************************************************************
    // Chain taken combinationally so both counters move the same cycle
    assign chain1 = counter1_control[`TCC_BIT_LINK] & reload0_event;

    tcc_counter counter0
    (
        .clk(CLOCK),
        .rst(RST),
        .ctrl(counter0_control),
        .reload_value(reload0),
        .single_res(RESOURCE),
        .pair_res(RESOURCE_PAIR),
        .chain_event(1'b0),
        .write_value(wr && (REG_ADDR == `TCC_OFS_VALUE0)),
        .write_data(REG_WDATA[15:0]),
        .count(count0),
        .reload_event(reload0_event)
    );

    tcc_counter counter1
    (
        .clk(CLOCK),
        .rst(RST),
        .ctrl(counter1_control),
        .reload_value(reload1),
        .single_res(RESOURCE),
        .pair_res(RESOURCE_PAIR),
        .chain_event(chain1), // [RULE_15] [RULE_16]
        .write_value(wr && (REG_ADDR == `TCC_OFS_VALUE1)),
        .write_data(REG_WDATA[15:0]),
        .count(count1),
        .reload_event(reload1_event)
    );

    // ************************************************************
    // Context ID comparator
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : gen_byte
            assign byte_equal[g] = ctx_byte_mask[g] // [RULE_01] [RULE_02]
                | (CONTEXT_ID[8*g+7:8*g]
                   == context_id_compare_value[8*g+7:8*g]);
        end
    endgenerate

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            CTX_MATCH <= 1'b0;
            RELOAD0_EVENT <= 1'b0;
            RELOAD1_EVENT <= 1'b0;
        end
        else
        begin
            CTX_MATCH <= &byte_equal; // [RULE_01]
            RELOAD0_EVENT <= reload0_event;
            RELOAD1_EVENT <= reload1_event;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb
    begin
        next_rdata = `TCC_RST_WORD;
        if (REG_ADDR == `TCC_OFS_CTRL0)
        begin
            next_rdata = counter0_control;
        end
        else if (REG_ADDR == `TCC_OFS_CTRL1)
        begin
            next_rdata = counter1_control;
        end
        else if (REG_ADDR == `TCC_OFS_RELOAD0)
        begin
            next_rdata = {16'h0000, reload0};
        end
        else if (REG_ADDR == `TCC_OFS_RELOAD1)
        begin
            next_rdata = {16'h0000, reload1};
        end
        else if (REG_ADDR == `TCC_OFS_VALUE0)
        begin
            next_rdata = {16'h0000, count0}; // [RULE_18]
        end
        else if (REG_ADDR == `TCC_OFS_VALUE1)
        begin
            next_rdata = {16'h0000, count1}; // [RULE_18]
        end
        else if (REG_ADDR == `TCC_OFS_CMP_LO)
        begin
            next_rdata = context_id_compare_value; // [RULE_03]
        end
        else if (REG_ADDR == `TCC_OFS_MASK)
        begin
            next_rdata = {28'h0000000, ctx_byte_mask}; // [RULE_20]
        end
        else if (REG_ADDR == `TCC_OFS_CLAIM_SET)
        begin
            next_rdata = {28'h0000000, `TCC_CLAIM_IMPL}; // [RULE_07]
        end
        else if (REG_ADDR == `TCC_OFS_CLAIM_CLR)
        begin
            next_rdata = {28'h0000000, claim_tag}; // [RULE_05]
        end
        else if (REG_ADDR == `TCC_OFS_PRE0)
        begin
            next_rdata = {24'h000000, PREAMBLE_0}; // [RULE_04]
        end
        else if (REG_ADDR == `TCC_OFS_PRE1)
        begin
            next_rdata = {24'h000000, PREAMBLE_1}; // [RULE_04]
        end
        else if (REG_ADDR == `TCC_OFS_PRE2)
        begin
            next_rdata = {24'h000000, PREAMBLE_2}; // [RULE_04]
        end
        else if (REG_ADDR == `TCC_OFS_PRE3)
        begin
            next_rdata = {24'h000000, PREAMBLE_3}; // [RULE_04]
        end
    end

    // Upper compare half and unmapped offsets fall through to zero
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            REG_RDATA <= `TCC_RST_WORD;
            REG_READY <= 1'b0;
        end
        else
        begin
            REG_READY <= REG_SEL;
            if (rd)
            begin
                REG_RDATA <= next_rdata;
            end
        end
    end
endmodule
